// [hdl/hw_cursor_pkg.sv]
// How it works
// - index port picks the register, data port then reads or writes it
// - cursor 1 extension on: height comes from the 8-bit extension register
// - cursor 1 base low bits 7-4 give data area offset bits 15-12
// - cursor 1 base high bits 5-0 give data area offset bits 21-16
// - cursor 1 base high bits 7-6 always read as zero
// - cursor 1 base low bits 3-0 select one of up to 16 patterns
// - usable patterns limited to 4KB divided by the mode's pattern size
// - cursor 1 X is signed 12-bit, low magnitude from X low register
// - X high: bit 7 sign, bits 2-0 magnitude 10-8, bits 6-3 reserved
// - cursor 1 Y is signed 12-bit, built like X from Y low and high
// - cursor 2 control bit 7 enables blinking at an external rate
// - cursor 2 bits 6 and 5 stretch vertically and horizontally, panel only
// - cursor 2 bit 4 picks border corner (0) or active area corner (1)
// - cursor 2 bit 3 lets its extension register set cursor 2 height
// - modes 000 off, 001 32x32 2bpp, 010 and 011 128x128 1bpp
// - modes 100 to 110 are 64x64 2bpp variants, 111 is reserved
// - after reset every cursor 2 control field is zero
// - cursor 1 control bit 3 enables cursor 1 vertical extension
`default_nettype none
package hw_cursor_pkg;

   // ********************************
   // io ports and register indices
   // ********************************
   localparam logic [15:0] INDEX_PORT = 16'h03d6;
   localparam logic [15:0] DATA_PORT = 16'h03d7;
   localparam logic [7:0] IDX_CURSOR1_CONTROL = 8'ha0;
   localparam logic [7:0] IDX_CURSOR1_HEIGHT_EXT = 8'ha1;
   localparam logic [7:0] IDX_CURSOR1_BASE_LOW_PATTERN = 8'ha2;
   localparam logic [7:0] IDX_CURSOR1_BASE_HIGH = 8'ha3;
   localparam logic [7:0] IDX_CURSOR1_XPOS_LOW = 8'ha4;
   localparam logic [7:0] IDX_CURSOR1_XPOS_HIGH = 8'ha5;
   localparam logic [7:0] IDX_CURSOR1_YPOS_LOW = 8'ha6;
   localparam logic [7:0] IDX_CURSOR1_YPOS_HIGH = 8'ha7;
   localparam logic [7:0] IDX_CURSOR2_CONTROL = 8'ha8;
   localparam logic [7:0] IDX_CURSOR2_HEIGHT_EXT = 8'ha9;

   // ********************************
   // field positions and reset values
   // ********************************
   localparam int CTL_BLINK_BIT = 7;
   localparam int CTL_VSTRETCH_BIT = 6;
   localparam int CTL_HSTRETCH_BIT = 5;
   localparam int CTL_ORIGIN_BIT = 4;
   localparam int CTL_EXT_BIT = 3;
   localparam int POS_SIGN_BIT = 7;
   localparam logic [7:0] POS_HIGH_MASK = 8'h87;
   localparam logic [7:0] BASE_HIGH_MASK = 8'h3f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;

   // ********************************
   // cursor modes and geometry
   // ********************************
   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_32_ANDXOR = 3'h1,
      MODE_128_TWO_COLOR = 3'h2,
      MODE_128_ONE_COLOR = 3'h3,
      MODE_64_THREE_COLOR = 3'h4,
      MODE_64_ANDXOR = 3'h5,
      MODE_64_FOUR_COLOR = 3'h6,
      MODE_RESERVED = 3'h7
   } cursor_mode_type;

   localparam logic [10:0] HEIGHT_32 = 11'h020;
   localparam logic [10:0] HEIGHT_64 = 11'h040;
   localparam logic [10:0] HEIGHT_128 = 11'h080;
   // pattern size as a shift: 256, 1024 and 2048 bytes
   localparam logic [3:0] PAT_SHIFT_32 = 4'h8;
   localparam logic [3:0] PAT_SHIFT_64 = 4'ha;
   localparam logic [3:0] PAT_SHIFT_128 = 4'hb;
   localparam logic [3:0] PAT_SHIFT_MIN = 4'h8;
   localparam logic [4:0] PATTERNS_MAX = 5'h10;
   localparam int EXT_LINE_SHIFT = 2;

endpackage : hw_cursor_pkg
`default_nettype wire

// [hdl/cursor_mode_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface cursor_mode_if;
   import hw_cursor_pkg::*;
   cursor_mode_type mode;
   logic ext_en;
   logic [7:0] ext_height;
   logic [3:0] pattern;
   logic active;
   logic [10:0] height;
   logic [11:0] pattern_offset;
   logic pattern_ok;
   modport regs (output mode, ext_en, ext_height, pattern,
                 input active, height, pattern_offset, pattern_ok);
   modport decode (input mode, ext_en, ext_height, pattern,
                   output active, height, pattern_offset, pattern_ok);
endinterface : cursor_mode_if
`default_nettype wire

// [hdl/cursor_mode_decode.sv]
`timescale 1ns/10ps
`default_nettype none
module cursor_mode_decode
   import hw_cursor_pkg::*;
(
   cursor_mode_if.decode m
);
   logic [10:0] mode_height;
   logic [3:0] pat_shift;
   logic [4:0] pat_count;
   logic [10:0] ext_lines;

   always_comb
   begin
      mode_height = 11'h000;
      pat_shift = PAT_SHIFT_MIN;
      m.active = 1'b1;
      case (m.mode)
         MODE_32_ANDXOR:
         begin
            mode_height = HEIGHT_32;
            pat_shift = PAT_SHIFT_32;
         end
         MODE_128_TWO_COLOR, MODE_128_ONE_COLOR:
         begin
            mode_height = HEIGHT_128;
            pat_shift = PAT_SHIFT_128;
         end
         MODE_64_THREE_COLOR, MODE_64_ANDXOR, MODE_64_FOUR_COLOR:
         begin
            mode_height = HEIGHT_64;
            pat_shift = PAT_SHIFT_64;
         end
         default:
            m.active = 1'b0;
      endcase
   end

   // register holds lines/4 - 1, so add one back before scaling
   assign ext_lines = 11'({3'h0, m.ext_height} + 11'h001) << EXT_LINE_SHIFT;
   assign m.height = m.ext_en ? ext_lines : mode_height;
   // the data area is 4KB, so fewer patterns fit as the pattern grows
   assign pat_count = PATTERNS_MAX >> (pat_shift - PAT_SHIFT_MIN);
   assign m.pattern_ok = m.active && ({1'b0, m.pattern} < pat_count);
   assign m.pattern_offset = 12'({8'h00, m.pattern} << pat_shift);
endmodule : cursor_mode_decode
`default_nettype wire

// [hdl/cursor_pos_convert.sv]
`timescale 1ns/10ps
`default_nettype none
module cursor_pos_convert
   import hw_cursor_pkg::*;
(
   input wire logic [7:0] i_low,
   input wire logic [7:0] i_high,
   output logic [11:0] o_pos
);
   logic [11:0] magnitude;

   // sign plus magnitude becomes two's complement for the pixel engine
   assign magnitude = {1'b0, i_high[2:0], i_low};
   assign o_pos = i_high[POS_SIGN_BIT] ? 12'(~magnitude + 12'h001) : magnitude;
endmodule : cursor_pos_convert
`default_nettype wire

// [hdl/hw_cursor_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module hw_cursor_regs
   import hw_cursor_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic i_panel_mode,
   input wire logic i_blink_phase,
   output logic [7:0] o_io_rdata,
   output logic o_io_rdata_valid,
   output logic [21:0] o_cursor1_base,
   output logic [21:0] o_cursor1_pattern_addr,
   output logic o_cursor1_pattern_ok,
   output logic [11:0] o_cursor1_x,
   output logic [11:0] o_cursor1_y,
   output logic [2:0] o_cursor1_mode,
   output logic [2:0] o_cursor2_mode,
   output logic [10:0] o_cursor1_height,
   output logic [10:0] o_cursor2_height,
   output logic [1:0] o_cursor_active,
   output logic [1:0] o_cursor_show,
   output logic [1:0] o_cursor_vstretch,
   output logic [1:0] o_cursor_hstretch,
   output logic [1:0] o_cursor_origin_active
);

   // ********************************
   // register state
   // ********************************
   logic [7:0] index_q;
   logic [7:0] cursor1_control_q;
   logic [7:0] cursor1_height_ext_q;
   logic [7:0] cursor1_base_low_pattern_q;
   logic [7:0] cursor1_base_high_q;
   logic [7:0] cursor1_xpos_low_q;
   logic [7:0] cursor1_xpos_high_q;
   logic [7:0] cursor1_ypos_low_q;
   logic [7:0] cursor1_ypos_high_q;
   logic [7:0] cursor2_control_q;
   logic [7:0] cursor2_height_ext_q;

   logic index_wr;
   logic data_wr;
   logic index_rd;
   logic data_rd;
   logic [7:0] read_value;
   logic [7:0] control [2];
   logic [11:0] pos [2];
   logic [21:0] base_d;

   // ********************************
   // io port decode
   // ********************************
   // both ports ignore all traffic while the clock enable is low
   assign index_wr = i_ce && i_io_wr && (i_io_addr == INDEX_PORT);
   assign data_wr = i_ce && i_io_wr && (i_io_addr == DATA_PORT);
   assign index_rd = i_ce && i_io_rd && (i_io_addr == INDEX_PORT);
   assign data_rd = i_ce && i_io_rd && (i_io_addr == DATA_PORT);

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         index_q <= INDEX_RESET;
      end
      else if (index_wr)
      begin
         index_q <= i_io_wdata;
      end
   end

   // ********************************
   // cursor 1 registers
   // ********************************
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cursor1_control_q <= REG_RESET;
         cursor1_height_ext_q <= REG_RESET;
      end
      else if (data_wr)
      begin
         if (index_q == IDX_CURSOR1_CONTROL)
         begin
            cursor1_control_q <= i_io_wdata;
         end
         if (index_q == IDX_CURSOR1_HEIGHT_EXT)
         begin
            cursor1_height_ext_q <= i_io_wdata;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cursor1_base_low_pattern_q <= REG_RESET;
         cursor1_base_high_q <= REG_RESET;
      end
      else if (data_wr)
      begin
         if (index_q == IDX_CURSOR1_BASE_LOW_PATTERN)
         begin
            cursor1_base_low_pattern_q <= i_io_wdata;
         end
         if (index_q == IDX_CURSOR1_BASE_HIGH)
         begin
            // reserved bits are never stored, so they read back as zero
            cursor1_base_high_q <= i_io_wdata & BASE_HIGH_MASK;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cursor1_xpos_low_q <= REG_RESET;
         cursor1_xpos_high_q <= REG_RESET;
         cursor1_ypos_low_q <= REG_RESET;
         cursor1_ypos_high_q <= REG_RESET;
      end
      else if (data_wr)
      begin
         if (index_q == IDX_CURSOR1_XPOS_LOW)
         begin
            cursor1_xpos_low_q <= i_io_wdata;
         end
         if (index_q == IDX_CURSOR1_XPOS_HIGH)
         begin
            cursor1_xpos_high_q <= i_io_wdata & POS_HIGH_MASK;
         end
         if (index_q == IDX_CURSOR1_YPOS_LOW)
         begin
            cursor1_ypos_low_q <= i_io_wdata;
         end
         if (index_q == IDX_CURSOR1_YPOS_HIGH)
         begin
            cursor1_ypos_high_q <= i_io_wdata & POS_HIGH_MASK;
         end
      end
   end

   // ********************************
   // cursor 2 registers
   // ********************************
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         cursor2_control_q <= REG_RESET;
         cursor2_height_ext_q <= REG_RESET;
      end
      else if (data_wr)
      begin
         if (index_q == IDX_CURSOR2_CONTROL)
         begin
            cursor2_control_q <= i_io_wdata;
         end
         if (index_q == IDX_CURSOR2_HEIGHT_EXT)
         begin
            cursor2_height_ext_q <= i_io_wdata;
         end
      end
   end

   // ********************************
   // read back
   // ********************************
   always_comb
   begin
      case (index_q)
         IDX_CURSOR1_CONTROL: read_value = cursor1_control_q;
         IDX_CURSOR1_HEIGHT_EXT: read_value = cursor1_height_ext_q;
         IDX_CURSOR1_BASE_LOW_PATTERN: read_value = cursor1_base_low_pattern_q;
         IDX_CURSOR1_BASE_HIGH: read_value = cursor1_base_high_q;
         IDX_CURSOR1_XPOS_LOW: read_value = cursor1_xpos_low_q;
         IDX_CURSOR1_XPOS_HIGH: read_value = cursor1_xpos_high_q;
         IDX_CURSOR1_YPOS_LOW: read_value = cursor1_ypos_low_q;
         IDX_CURSOR1_YPOS_HIGH: read_value = cursor1_ypos_high_q;
         IDX_CURSOR2_CONTROL: read_value = cursor2_control_q;
         IDX_CURSOR2_HEIGHT_EXT: read_value = cursor2_height_ext_q;
         default: read_value = 8'h00;
      endcase
   end

   // a read answers one cycle later; a write in the same cycle is not seen
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_io_rdata <= 8'h00;
         o_io_rdata_valid <= 1'b0;
      end
      else if (i_ce)
      begin
         o_io_rdata_valid <= index_rd || data_rd;
         if (index_rd)
         begin
            o_io_rdata <= index_q;
         end
         else if (data_rd)
         begin
            o_io_rdata <= read_value;
         end
         else
         begin
            o_io_rdata <= 8'h00;
         end
      end
   end

   // ********************************
   // per-cursor mode decode
   // ********************************
   assign control[0] = cursor1_control_q;
   assign control[1] = cursor2_control_q;

   cursor_mode_if mode_bus [2] ();

   assign mode_bus[0].mode = cursor_mode_type'(cursor1_control_q[2:0]);
   assign mode_bus[0].ext_en = cursor1_control_q[CTL_EXT_BIT];
   assign mode_bus[0].ext_height = cursor1_height_ext_q;
   assign mode_bus[0].pattern = cursor1_base_low_pattern_q[3:0];
   assign mode_bus[1].mode = cursor_mode_type'(cursor2_control_q[2:0]);
   assign mode_bus[1].ext_en = cursor2_control_q[CTL_EXT_BIT];
   assign mode_bus[1].ext_height = cursor2_height_ext_q;
   // cursor 2 pattern select lives in a register this bank does not hold
   assign mode_bus[1].pattern = 4'h0;

   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_cursor
         cursor_mode_decode u_decode
         (
            .m(mode_bus[c])
         );

         always_ff @(posedge i_clk)
         begin
            if (!i_resetn)
            begin
               o_cursor_active[c] <= 1'b0;
               o_cursor_show[c] <= 1'b0;
               o_cursor_vstretch[c] <= 1'b0;
               o_cursor_hstretch[c] <= 1'b0;
               o_cursor_origin_active[c] <= 1'b0;
            end
            else if (i_ce)
            begin
               o_cursor_active[c] <= mode_bus[c].active;
               // blink rate comes from the panel timing block as a phase
               o_cursor_show[c] <= mode_bus[c].active &&
                  (!control[c][CTL_BLINK_BIT] || i_blink_phase);
               // stretching has no meaning on crt output
               o_cursor_vstretch[c] <= control[c][CTL_VSTRETCH_BIT] && i_panel_mode;
               o_cursor_hstretch[c] <= control[c][CTL_HSTRETCH_BIT] && i_panel_mode;
               o_cursor_origin_active[c] <= control[c][CTL_ORIGIN_BIT];
            end
         end
      end
   endgenerate

   // ********************************
   // cursor 1 positions
   // ********************************
   cursor_pos_convert u_xpos
   (
      .i_low(cursor1_xpos_low_q),
      .i_high(cursor1_xpos_high_q),
      .o_pos(pos[0])
   );

   cursor_pos_convert u_ypos
   (
      .i_low(cursor1_ypos_low_q),
      .i_high(cursor1_ypos_high_q),
      .o_pos(pos[1])
   );

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_cursor1_x <= 12'h000;
         o_cursor1_y <= 12'h000;
      end
      else if (i_ce)
      begin
         o_cursor1_x <= pos[0];
         o_cursor1_y <= pos[1];
      end
   end

   // ********************************
   // cursor 1 data area
   // ********************************
   // the area is 4KB aligned, so the low twelve offset bits are zero
   assign base_d = {cursor1_base_high_q[5:0], cursor1_base_low_pattern_q[7:4], 12'h000};

   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_cursor1_base <= 22'h000000;
         o_cursor1_pattern_addr <= 22'h000000;
         o_cursor1_pattern_ok <= 1'b0;
      end
      else if (i_ce)
      begin
         o_cursor1_base <= base_d;
         // an oversize select would wrap inside the area; flag shows it
         o_cursor1_pattern_addr <= base_d | {10'h000, mode_bus[0].pattern_offset};
         o_cursor1_pattern_ok <= mode_bus[0].pattern_ok;
      end
   end

   // ********************************
   // heights and modes
   // ********************************
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_cursor1_height <= 11'h000;
         o_cursor2_height <= 11'h000;
         o_cursor1_mode <= MODE_OFF;
         o_cursor2_mode <= MODE_OFF;
      end
      else if (i_ce)
      begin
         o_cursor1_height <= mode_bus[0].height;
         o_cursor2_height <= mode_bus[1].height;
         o_cursor1_mode <= mode_bus[0].mode;
         o_cursor2_mode <= mode_bus[1].mode;
      end
   end

endmodule : hw_cursor_regs
`default_nettype wire

// [test/hw_cursor_regs_props.sv]
`timescale 1ns/10ps
`default_nettype none
module hw_cursor_regs_props
   import hw_cursor_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_rd,
   input wire logic i_panel_mode,
   input wire logic [7:0] o_io_rdata,
   input wire logic o_io_rdata_valid,
   input wire logic [21:0] o_cursor1_base,
   input wire logic [21:0] o_cursor1_pattern_addr,
   input wire logic [2:0] o_cursor2_mode,
   input wire logic [10:0] o_cursor2_height,
   input wire logic [1:0] o_cursor_active,
   input wire logic [1:0] o_cursor_show,
   input wire logic [1:0] o_cursor_vstretch,
   input wire logic [1:0] o_cursor_hstretch
);
   // ********************************
   // properties
   // ********************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_read_taken;
      i_ce && i_io_rd && (i_io_addr == INDEX_PORT || i_io_addr == DATA_PORT);
   endsequence
   sequence s_answer;
      o_io_rdata_valid;
   endsequence
   property p_read_answer;
      s_read_taken |=> s_answer;
   endproperty
   property p_no_answer;
      !(i_ce && i_io_rd && (i_io_addr == INDEX_PORT || i_io_addr == DATA_PORT))
         |=> !o_io_rdata_valid;
   endproperty
   property p_rdata_idle;
      !o_io_rdata_valid |-> o_io_rdata == 8'h00;
   endproperty
   property p_pattern_base;
      o_cursor1_base[11:0] == 12'h000 && o_cursor1_pattern_addr[21:12] == o_cursor1_base[21:12];
   endproperty
   property p_show_active;
      (o_cursor_show & ~o_cursor_active) == 2'b00;
   endproperty
   property p_stretch_panel;
      ($past(i_ce) && !$past(i_panel_mode)) |-> (o_cursor_vstretch | o_cursor_hstretch) == 2'b00;
   endproperty
   property p_active_mode;
      o_cursor_active[1] == (o_cursor2_mode != 3'h0 && o_cursor2_mode != 3'h7);
   endproperty
   property p_height_mult4;
      o_cursor2_height[1:0] == 2'b00;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   a_no_answer: assert property (p_no_answer) else $error("stray read answer");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_pattern_base: assert property (p_pattern_base) else $error("base layout");
   a_show_active: assert property (p_show_active) else $error("shown while off");
   a_stretch_panel: assert property (p_stretch_panel) else $error("crt stretch");
   a_active_mode: assert property (p_active_mode) else $error("mode decode");
   a_height_mult4: assert property (p_height_mult4) else $error("height step");
endmodule : hw_cursor_regs_props
bind hw_cursor_regs hw_cursor_regs_props u_hw_cursor_regs_props (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
   .i_panel_mode(i_panel_mode), .o_io_rdata(o_io_rdata), .o_io_rdata_valid(o_io_rdata_valid),
   .o_cursor1_base(o_cursor1_base), .o_cursor1_pattern_addr(o_cursor1_pattern_addr),
   .o_cursor2_mode(o_cursor2_mode), .o_cursor2_height(o_cursor2_height),
   .o_cursor_active(o_cursor_active), .o_cursor_show(o_cursor_show),
   .o_cursor_vstretch(o_cursor_vstretch), .o_cursor_hstretch(o_cursor_hstretch));
`default_nettype wire

// [test/hw_cursor_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module hw_cursor_regs_tb_top
   import hw_cursor_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_ce = 1'b1;
   logic [15:0] i_io_addr = 16'h0000;
   logic i_io_wr = 1'b0;
   logic i_io_rd = 1'b0;
   logic [7:0] i_io_wdata = 8'h00;
   logic i_panel_mode = 1'b0;
   logic i_blink_phase = 1'b0;
   logic [7:0] o_io_rdata;
   logic o_io_rdata_valid;
   logic [21:0] o_cursor1_base;
   logic [21:0] o_cursor1_pattern_addr;
   logic o_cursor1_pattern_ok;
   logic [11:0] o_cursor1_x;
   logic [11:0] o_cursor1_y;
   logic [2:0] o_cursor1_mode;
   logic [2:0] o_cursor2_mode;
   logic [10:0] o_cursor1_height;
   logic [10:0] o_cursor2_height;
   logic [1:0] o_cursor_active;
   logic [1:0] o_cursor_show;
   logic [1:0] o_cursor_vstretch;
   logic [1:0] o_cursor_hstretch;
   logic [1:0] o_cursor_origin_active;
   int n_mismatch = 0;
   int checked = 0;
   int m;
   logic [7:0] t_val [7] = '{8'h0f, 8'h5a, 8'hff, 8'h34, 8'hfb, 8'hff, 8'h7f};
   logic [7:0] t_mask [7] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'h87, 8'hff, 8'h87};
   logic [10:0] exp_h [8] = '{11'h000, HEIGHT_32, HEIGHT_128, HEIGHT_128, HEIGHT_64,
      HEIGHT_64, HEIGHT_64, 11'h000};

   hw_cursor_regs u_hw_cursor_regs (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_io_addr(i_io_addr),
      .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
      .i_panel_mode(i_panel_mode), .i_blink_phase(i_blink_phase), .o_io_rdata(o_io_rdata),
      .o_io_rdata_valid(o_io_rdata_valid), .o_cursor1_base(o_cursor1_base),
      .o_cursor1_pattern_addr(o_cursor1_pattern_addr),
      .o_cursor1_pattern_ok(o_cursor1_pattern_ok), .o_cursor1_x(o_cursor1_x),
      .o_cursor1_y(o_cursor1_y), .o_cursor1_mode(o_cursor1_mode),
      .o_cursor2_mode(o_cursor2_mode), .o_cursor1_height(o_cursor1_height),
      .o_cursor2_height(o_cursor2_height), .o_cursor_active(o_cursor_active),
      .o_cursor_show(o_cursor_show), .o_cursor_vstretch(o_cursor_vstretch),
      .o_cursor_hstretch(o_cursor_hstretch), .o_cursor_origin_active(o_cursor_origin_active));

   // ********************************
   // tasks
   // ********************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // strobes are one-cycle pulses launched at the falling edge
   task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
      @(negedge i_clk);
      i_io_addr = addr;
      i_io_wdata = data;
      i_io_wr = 1'b1;
      @(negedge i_clk);
      i_io_wr = 1'b0;
   endtask : io_write

   task automatic io_read(input logic [15:0] addr, input logic v, input logic [7:0] d);
      @(negedge i_clk);
      i_io_addr = addr;
      i_io_rd = 1'b1;
      @(negedge i_clk);
      i_io_rd = 1'b0;
      check(32'(o_io_rdata_valid), 32'(v));
      check(32'(o_io_rdata), 32'(d));
   endtask : io_read

   task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
      io_write(INDEX_PORT, idx);
      io_write(DATA_PORT, d);
      @(negedge i_clk);
   endtask : reg_write

   task automatic reg_read(input logic [7:0] idx, input logic [7:0] d);
      io_write(INDEX_PORT, idx);
      io_read(DATA_PORT, 1'b1, d);
   endtask : reg_read

   task automatic stop_test();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // ********************************
   // clock, watchdog and tests
   // ********************************
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   // the tests need well under 1000 cycles
   initial
   begin
      #300000;
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      io_read(INDEX_PORT, 1'b1, INDEX_RESET);
      for (m = 1; m < 9; m++)
         reg_read(8'ha0 + 8'(m), REG_RESET);
      check(32'({o_cursor2_mode, o_cursor_active, o_cursor_show, o_cursor_origin_active}), 0);
      for (m = 0; m < 7; m++)
      begin
         reg_write(8'ha1 + 8'(m), t_val[m]);
         reg_read(8'ha1 + 8'(m), t_val[m] & t_mask[m]);
      end
      reg_write(IDX_CURSOR1_CONTROL, 8'h09);
      check(32'(o_cursor1_base), 32'h3f5000);
      check(32'(o_cursor1_pattern_addr), 32'h3f5a00);
      check(32'(o_cursor1_pattern_ok), 1);
      check(32'(o_cursor1_height), 32'h040);
      check(32'(o_cursor1_x), 32'hccc);
      check(32'(o_cursor1_y), 32'h7ff);
      check(32'({o_cursor1_mode, o_cursor_active[0], o_cursor_show[0]}), 32'h07);
      // pattern 10 does not fit two 2KB patterns
      reg_write(IDX_CURSOR1_CONTROL, 8'h02);
      check(32'(o_cursor1_pattern_ok), 0);
      check(32'(o_cursor1_height), 32'(HEIGHT_128));
      check(32'(o_cursor1_mode), 32'(MODE_128_TWO_COLOR));
      reg_read(IDX_CURSOR1_CONTROL, 8'h02);
      for (m = 0; m < 8; m++)
      begin
         reg_write(IDX_CURSOR2_CONTROL, 8'(m));
         check(32'(o_cursor2_height), 32'(exp_h[m]));
         check(32'(o_cursor2_mode), 32'(m));
         check(32'(o_cursor_active[1]), 32'(m != 0 && m != 7));
      end
      reg_write(IDX_CURSOR2_HEIGHT_EXT, 8'hff);
      reg_write(IDX_CURSOR2_CONTROL, 8'h0c);
      check(32'(o_cursor2_height), 32'h400);
      reg_read(IDX_CURSOR2_HEIGHT_EXT, 8'hff);
      i_panel_mode = 1'b1;
      reg_write(IDX_CURSOR2_CONTROL, 8'hf1);
      check(32'({o_cursor_show[1], o_cursor_vstretch[1], o_cursor_hstretch[1],
         o_cursor_origin_active[1]}), 32'h7);
      i_blink_phase = 1'b1;
      i_panel_mode = 1'b0;
      repeat (2) @(negedge i_clk);
      check(32'({o_cursor_show[1], o_cursor_vstretch[1], o_cursor_hstretch[1],
         o_cursor_origin_active[1]}), 32'h9);
      reg_write(8'hb0, 8'h55);
      reg_read(8'hb0, 8'h00);
      io_read(16'h03d5, 1'b0, 8'h00);
      io_write(INDEX_PORT, IDX_CURSOR1_XPOS_LOW);
      i_ce = 1'b0;
      io_write(DATA_PORT, 8'h99);
      i_ce = 1'b1;
      io_read(DATA_PORT, 1'b1, 8'h34);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      reg_read(IDX_CURSOR2_CONTROL, REG_RESET);
      stop_test();
   end
endmodule : hw_cursor_regs_tb_top
`default_nettype wire
